/* hdl/bps_pkg.sv */
package bps_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NPIX   = 16;
   localparam int NPLANE = 8;
   localparam int NSEG   = 16;
   localparam int PIXW   = 4;
   localparam int PLW    = 3;
   localparam int SEGW   = 4;
   localparam int WGTW   = 8;
   localparam int SUMW   = 11;
   localparam int HOLDW  = 16;
   localparam int DIVW   = 6;
   // ----------------------------------------------------------------
   // Table layout
   // ----------------------------------------------------------------
   localparam logic       TBL_WEIGHT   = 1'b0;
   localparam logic       TBL_SEG      = 1'b1;
   localparam int         SEG_COMP_BIT = 7;
   localparam int         SEG_PL_LSB   = 0;
   localparam logic [7:0] WEIGHT_RST   = 8'h00;
   localparam logic [7:0] SEG_RST      = 8'h00;
   localparam logic [7:0] RED_FULL     = 8'hFF;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ  = 40;
   localparam int TICK_NS  = 1000;
   localparam int TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;
   localparam logic [DIVW-1:0] DIV_LAST = DIVW'(TICK_CYC - 1);

   typedef enum logic [1:0] {
      BPS_IDLE = 2'b00,
      BPS_LOAD = 2'b01,
      BPS_RST  = 2'b11,
      BPS_HOLD = 2'b10
   } bps_state_t;

   typedef struct packed {
      bps_state_t                          state;
      logic [NPLANE-1:0][WGTW-1:0]         weight;
      logic [NSEG-1:0][7:0]                segTbl;
      logic [1:0][NPIX-1:0][7:0]           frame;
      logic                                wrBank;
      logic [PIXW-1:0]                     wrAddr;
      logic                                dispBank;
      logic                                pending;
      logic                                alt;
      logic [SEGW-1:0]                     seg;
      logic [SEGW-1:0]                     sub;
      logic [PIXW-1:0]                     pixAddr;
      logic [HOLDW-1:0]                    holdCnt;
      logic [DIVW-1:0]                     div;
      logic                                tick;
      logic                                planeValid;
      logic                                planeData;
      logic [PIXW-1:0]                     planeAddr;
      logic                                mirrorReset;
      logic [PLW-1:0]                      curPlane;
      logic                                curComp;
      logic                                displaying;
   } bps_regs_t;
endpackage

/* hdl/bit_plane_sequencer.sv */
`timescale 1ns/1ps
// How it works
// - one whole plane shown per display interval
// - complement segment inverts every mirror bit
// - arbitrary, repeated plane weights accepted
// - equal-weight plane pairs 0/1, 2/3, 4/5, 6/7 swapped per pixel, frame
// - hold time equals plane weight times unit
// - table may list a plane several times
// - mirror reset pulse after each plane load
// - segment groups repeat within each frame
// - sub-frame count set by refresh ratio
// - one programmable table used every frame
// - only red byte feeds intensity
module bit_plane_sequencer (
   input  wire logic                          mclk,
   input  wire logic                          sys_rst,
   input  wire logic                          frameStart,
   input  wire logic                          pixValid,
   input  wire logic [7:0]                    pixRed,
   input  wire logic                          tblWe,
   input  wire logic                          tblSel,
   input  wire logic [bps_pkg::SEGW-1:0]      tblAddr,
   input  wire logic [7:0]                    tblData,
   input  wire logic [bps_pkg::SEGW-1:0]      cfgLastSeg,
   input  wire logic [bps_pkg::SEGW-1:0]      cfgLastSub,
   input  wire logic [bps_pkg::WGTW-1:0]      cfgUnit,
   output logic                               planeValid,
   output logic                               planeData,
   output logic [bps_pkg::PIXW-1:0]           planeAddr,
   output logic                               mirrorReset,
   output logic [bps_pkg::PLW-1:0]            curPlane,
   output logic                               curComp,
   output logic                               displaying
);
   import bps_pkg::*;

   bps_regs_t r_q;
   bps_regs_t r_d;

   logic [SUMW-1:0]   sumW;
   logic [7:0]        pixVal;
   logic [SUMW-1:0]   level;
   logic [NPLANE-1:0] bits;
   logic [PLW-1:0]    segPlane;
   logic              segComp;

   // ----------------------------------------------------------------
   // Plane decomposition
   // ----------------------------------------------------------------
   // Greedy from the top plane; planes must be listed in rising weight
   // so that every level up to the sum is reachable.
   function automatic logic [NPLANE-1:0] decompose(
      input logic [SUMW-1:0]           lvl,
      input logic [NPLANE-1:0][WGTW-1:0] w,
      input logic                      swap);
      logic [SUMW-1:0]   rem;
      logic [NPLANE-1:0] b;
      logic              t;
      rem = lvl;
      b   = '0;
      for (int i = NPLANE - 1; i >= 0; i--) begin
         if (w[i] != '0 && SUMW'(w[i]) <= rem) begin
            b[i] = 1'b1;
            rem  = rem - SUMW'(w[i]);
         end
      end
      // Equal-weight pairs give the same light either way round
      if (swap) begin
         for (int i = 0; i < NPLANE - 1; i += 2) begin
            if (w[i] == w[i+1]) begin
               t      = b[i];
               b[i]   = b[i+1];
               b[i+1] = t;
            end
         end
      end
      return b;
   endfunction

   always_comb begin
      sumW = '0;
      for (int i = 0; i < NPLANE; i++) begin
         sumW = sumW + SUMW'(r_q.weight[i]);
      end
      pixVal   = r_q.frame[r_q.dispBank][r_q.pixAddr];
      level    = SUMW'((32'(pixVal) * 32'(sumW) + 32'(127)) / 32'(RED_FULL));
      bits     = decompose(level, r_q.weight, r_q.alt ^ r_q.pixAddr[0]);
      segPlane = r_q.segTbl[r_q.seg][SEG_PL_LSB +: PLW];
      segComp  = r_q.segTbl[r_q.seg][SEG_COMP_BIT];
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_d             = r_q;
      r_d.planeValid  = 1'b0;
      r_d.mirrorReset = 1'b0;
      r_d.tick        = 1'b0;
      if (r_q.div == DIV_LAST) begin
         r_d.div  = '0;
         r_d.tick = 1'b1;
      end else begin
         r_d.div = r_q.div + 1'b1;
      end
      if (tblWe) begin
         if (tblSel == TBL_WEIGHT) begin
            r_d.weight[tblAddr[PLW-1:0]] = tblData;
         end else begin
            r_d.segTbl[tblAddr] = tblData;
         end
      end
      // Only red is stored; other colours never reach the planes
      if (pixValid) begin
         r_d.frame[r_q.wrBank][r_q.wrAddr] = pixRed;
         r_d.wrAddr                        = r_q.wrAddr + 1'b1;
      end
      if (frameStart) begin
         r_d.wrBank  = ~r_q.wrBank;
         r_d.wrAddr  = '0;
         r_d.pending = 1'b1;
      end
      unique case (r_q.state)
         BPS_IDLE: begin
            r_d.displaying = 1'b0;
            if (r_q.pending) begin
               r_d.state    = BPS_LOAD;
               // Show the bank closed by frameStart, not the one now filling
               r_d.dispBank = ~r_q.wrBank;
               r_d.pending  = frameStart;
               r_d.alt      = ~r_q.alt;
               r_d.seg      = '0;
               r_d.sub      = '0;
               r_d.pixAddr  = '0;
            end
         end
         BPS_LOAD: begin
            // Mirrors keep the previous plane until the reset pulse
            r_d.planeValid = 1'b1;
            r_d.planeData  = bits[segPlane] ^ segComp;
            r_d.planeAddr  = r_q.pixAddr;
            r_d.curPlane   = segPlane;
            r_d.curComp    = segComp;
            r_d.pixAddr    = r_q.pixAddr + 1'b1;
            if (r_q.pixAddr == PIXW'(NPIX - 1)) begin
               r_d.state = BPS_RST;
            end
         end
         BPS_RST: begin
            r_d.mirrorReset = 1'b1;
            r_d.displaying  = 1'b1;
            r_d.holdCnt     = HOLDW'(r_q.weight[r_q.curPlane]) * HOLDW'(cfgUnit);
            r_d.state       = BPS_HOLD;
         end
         BPS_HOLD: begin
            if (r_q.holdCnt != '0) begin
               if (r_q.tick) begin
                  r_d.holdCnt = r_q.holdCnt - 1'b1;
               end
            end else if (r_q.seg != cfgLastSeg) begin
               r_d.seg   = r_q.seg + 1'b1;
               r_d.state = BPS_LOAD;
            end else if (r_q.sub != cfgLastSub) begin
               r_d.seg   = '0;
               r_d.sub   = r_q.sub + 1'b1;
               r_d.state = BPS_LOAD;
            end else begin
               r_d.state = BPS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         r_q        <= '0;
         r_q.state  <= BPS_IDLE;
         r_q.weight <= {NPLANE{WEIGHT_RST}};
         r_q.segTbl <= {NSEG{SEG_RST}};
      end else begin
         r_q <= r_d;
      end
   end

   assign planeValid  = r_q.planeValid;
   assign planeData   = r_q.planeData;
   assign planeAddr   = r_q.planeAddr;
   assign mirrorReset = r_q.mirrorReset;
   assign curPlane    = r_q.curPlane;
   assign curComp     = r_q.curComp;
   assign displaying  = r_q.displaying;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_one_plane;
      planeValid && $past(planeValid) |-> $stable(curPlane) && $stable(curComp);
   endproperty
   a_one_plane: assert property (p_one_plane) else $error("plane changed mid load");

   property p_comp;
      r_q.state == BPS_LOAD |=> planeData == ($past(bits[segPlane]) ^ curComp);
   endproperty
   a_comp: assert property (p_comp) else $error("complement data wrong");

   property p_reset_after_load;
      planeValid && planeAddr == PIXW'(NPIX - 1) |=> mirrorReset ##1 !mirrorReset;
   endproperty
   a_reset_after_load: assert property (p_reset_after_load) else $error("no reset pulse");

   property p_reset_cause;
      mirrorReset |-> $past(planeValid) && $past(planeAddr) == PIXW'(NPIX - 1);
   endproperty
   a_reset_cause: assert property (p_reset_cause) else $error("reset without load");

   property p_hold_len;
      mirrorReset |-> r_q.holdCnt == HOLDW'(r_q.weight[curPlane]) * HOLDW'(cfgUnit);
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold length wrong");

   property p_no_load_in_hold;
      r_q.state == BPS_HOLD && r_q.holdCnt != '0 |=> !planeValid;
   endproperty
   a_no_load_in_hold: assert property (p_no_load_in_hold) else $error("load during hold");

   property p_frame_end;
      r_q.state == BPS_HOLD ##1 r_q.state == BPS_IDLE |->
         $past(r_q.sub) == cfgLastSub && $past(r_q.seg) == cfgLastSeg;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("frame ended early");

   property p_sub_wrap;
      r_q.state == BPS_HOLD && r_q.holdCnt == '0 && r_q.seg == cfgLastSeg &&
         r_q.sub != cfgLastSub |=> r_q.seg == '0 && r_q.sub == $past(r_q.sub) + 1'b1;
   endproperty
   a_sub_wrap: assert property (p_sub_wrap) else $error("sub-frame not repeated");

   property p_start;
      r_q.state == BPS_IDLE && r_q.pending |=>
         r_q.seg == '0 && r_q.sub == '0 && r_q.alt != $past(r_q.alt);
   endproperty
   a_start: assert property (p_start) else $error("bad frame start");

   c_reset:  cover property (mirrorReset);
   c_comp:   cover property (planeValid && curComp);
   c_sub:    cover property (r_q.sub != '0 && mirrorReset);
   c_done:   cover property (r_q.state == BPS_HOLD ##1 r_q.state == BPS_IDLE);
endmodule

/* verification/bps_mirror_model.sv */
`timescale 1ns/1ps
module bps_mirror_model (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        planeValid,
   input  wire logic        planeData,
   input  wire logic [3:0]  planeAddr,
   input  wire logic        mirrorReset,
   output logic      [15:0] mirrors,
   output logic      [4:0]  loadsSeen,
   output logic             tailOk
);
   logic [15:0] cells;
   logic [4:0]  cnt;
   logic        lastTail;

   // Cells fill freely; mirrors only move on a reset pulse, so a half
   // loaded plane can never show
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cells     <= 16'h0000;
         mirrors   <= 16'h0000;
         cnt       <= 5'h00;
         loadsSeen <= 5'h00;
         lastTail  <= 1'b0;
         tailOk    <= 1'b0;
      end else begin
         lastTail <= planeValid && (planeAddr == 4'hF);
         if (planeValid) begin
            cells[planeAddr] <= planeData;
            cnt              <= cnt + 5'h01;
         end
         if (mirrorReset) begin
            mirrors   <= cells;
            loadsSeen <= cnt;
            tailOk    <= lastTail;
            cnt       <= 5'h00;
         end
      end
   end
endmodule

/* verification/bit_plane_sequencer_test.sv */
`timescale 1ns/1ps
module bit_plane_sequencer_test;
   import bps_pkg::*;
   logic             mclk, sys_rst, frameStart, pixValid, tblWe, tblSel;
   logic [7:0]       pixRed, tblData;
   logic [SEGW-1:0]  tblAddr, cfgLastSeg, cfgLastSub;
   logic [WGTW-1:0]  cfgUnit;
   logic             planeValid, planeData, mirrorReset, curComp, displaying, tailOk;
   logic [PIXW-1:0]  planeAddr;
   logic [PLW-1:0]   curPlane;
   logic [15:0]      mirrors;
   logic [4:0]       loadsSeen;
   logic [7:0]       segs [16];
   int               miscompares = 0, samples_checked = 0, cyc = 0;
   localparam int    WT [8] = '{1, 1, 3, 3, 5, 5, 9, 9};
   localparam int    SUMWT = 36;

   bit_plane_sequencer dut_u (.mclk(mclk), .sys_rst(sys_rst), .frameStart(frameStart),
      .pixValid(pixValid), .pixRed(pixRed), .tblWe(tblWe), .tblSel(tblSel),
      .tblAddr(tblAddr), .tblData(tblData), .cfgLastSeg(cfgLastSeg),
      .cfgLastSub(cfgLastSub), .cfgUnit(cfgUnit), .planeValid(planeValid),
      .planeData(planeData), .planeAddr(planeAddr), .mirrorReset(mirrorReset),
      .curPlane(curPlane), .curComp(curComp), .displaying(displaying));
   bps_mirror_model model_u (.mclk(mclk), .sys_rst(sys_rst), .planeValid(planeValid),
      .planeData(planeData), .planeAddr(planeAddr), .mirrorReset(mirrorReset),
      .mirrors(mirrors), .loadsSeen(loadsSeen), .tailOk(tailOk));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Hang guard: both runs together need under a fifth of this
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         miscompares++;
         summarize();
      end
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Greedy split from the heaviest plane; equal pairs swap when asked
   function automatic logic [7:0] exp_planes(int red, logic swp);
      int         lvl;
      logic [7:0] b;
      lvl = (red * SUMWT * 2 + 255) / 510;
      for (int p = 7; p >= 0; p--) begin
         b[p] = (lvl >= WT[p]);
         if (b[p]) lvl -= WT[p];
      end
      if (swp) b = {b[6], b[7], b[4], b[5], b[2], b[3], b[0], b[1]};
      return b;
   endfunction
   function automatic logic [15:0] exp_mirrors(logic rev, logic altv, logic [7:0] e);
      logic [7:0]  b;
      logic [15:0] m;
      for (int i = 0; i < 16; i++) begin
         b = exp_planes(rev ? 255 - i * 17 : i * 17, altv ^ (i % 2 == 1));
         m[i] = b[e[2:0]] ^ e[SEG_COMP_BIT];
      end
      return m;
   endfunction
   task automatic wr_tbl(logic sel, logic [3:0] a, logic [7:0] d);
      @(posedge mclk);
      tblWe   <= 1'b1;
      tblSel  <= sel;
      tblAddr <= a;
      tblData <= d;
      @(posedge mclk);
      tblWe <= 1'b0;
   endtask
   task automatic send_frame(logic rev);
      for (int i = 0; i < 16; i++) begin
         @(posedge mclk);
         pixValid <= 1'b1;
         pixRed   <= rev ? 8'(255 - i * 17) : 8'(i * 17);
      end
      @(posedge mclk);
      pixValid   <= 1'b0;
      frameStart <= 1'b1;
      @(posedge mclk);
      frameStart <= 1'b0;
   endtask
   task automatic run_check(logic rev, logic altv, int nseg, int nsub);
      int         t0, lastW, waitc, extra;
      logic [7:0] e;
      lastW = -1;
      t0 = 0;
      extra = 0;
      for (int k = 0; k < nseg * nsub; k++) begin
         e = segs[k % nseg];
         waitc = 0;
         do begin
            @(posedge mclk);
            #1;
            waitc++;
         end while (mirrorReset !== 1'b1 && waitc < 2000);
         chk("reset pulse", 1, mirrorReset);
         // Free-running tick: first tick lands anywhere in one tick period
         if (lastW >= 0) chk("hold min", 1, (cyc - t0) >= lastW * TICK_CYC - TICK_CYC + NPIX + 3);
         if (lastW >= 0) chk("hold max", 1, (cyc - t0) <= lastW * TICK_CYC + NPIX + 2);
         t0 = cyc;
         lastW = WT[e[2:0]];
         chk("plane", e[2:0], curPlane);
         chk("complement", e[SEG_COMP_BIT], curComp);
         @(posedge mclk);
         #1;
         chk("loads per plane", 16, loadsSeen);
         chk("reset after last load", 1, tailOk);
         chk("displaying", 1, displaying);
         chk("mirrors", exp_mirrors(rev, altv, e), mirrors);
      end
      repeat (600) begin
         @(posedge mclk);
         #1;
         if (mirrorReset === 1'b1) extra++;
      end
      chk("extra resets", 0, extra);
      chk("idle after run", 0, displaying);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_frame_a();
      for (int p = 0; p < 8; p++) wr_tbl(TBL_WEIGHT, 4'(p), 8'(WT[p]));
      segs[0] = 8'h07;
      segs[1] = 8'h80;
      segs[2] = 8'h07;
      for (int k = 0; k < 3; k++) wr_tbl(TBL_SEG, 4'(k), segs[k]);
      @(posedge mclk);
      cfgLastSeg <= 4'h2;
      cfgLastSub <= 4'h1;
      send_frame(1'b0);
      run_check(1'b0, 1'b1, 3, 2);
      $display("test frame_a done");
   endtask
   task automatic test_frame_b();
      segs[0] = 8'h84;
      segs[1] = 8'h06;
      for (int k = 0; k < 2; k++) wr_tbl(TBL_SEG, 4'(k), segs[k]);
      @(posedge mclk);
      cfgLastSeg <= 4'h1;
      cfgLastSub <= 4'h2;
      send_frame(1'b1);
      run_check(1'b1, 1'b0, 2, 3);
      $display("test frame_b done");
   endtask

   initial begin
      sys_rst = 1'b1;
      {frameStart, pixValid, tblWe, tblSel} = 4'h0;
      {pixRed, tblData, tblAddr, cfgLastSeg, cfgLastSub} = '0;
      cfgUnit = 8'h01;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      #1;
      chk("quiet after reset", 0, {planeValid, mirrorReset, displaying});
      test_frame_a();
      test_frame_b();
      summarize();
   end
endmodule
